// ==== wer_pkg.sv ====
package wer_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] HOST_STS_ADDR = 8'h00;
    localparam logic [7:0] HOST_PU_EN_ADDR = 8'h04;
    localparam logic [7:0] HOST_SMI_EN_ADDR = 8'h08;
    localparam logic [7:0] HOST_IRQ_EN_ADDR = 8'h0c;
    localparam logic [7:0] SIG_VALUE_ADDR = 8'h10;
    localparam logic [7:0] CORE_STS_ADDR = 8'h14;
    localparam logic [7:0] CORE_EN_ADDR = 8'h18;
    localparam logic [7:0] CTRL1_ADDR = 8'h1c;
    localparam logic [7:0] CTRL2_ADDR = 8'h20;
    localparam logic [7:0] CTRL3_ADDR = 8'h24;
    localparam logic [7:0] IEN2_ADDR = 8'h28;
    localparam logic [7:0] CFG_LOW_ADDR = 8'h2c;
    localparam logic [7:0] CFG_HIGH_ADDR = 8'h30;
    localparam logic [7:0] PB_DOUT_ADDR = 8'h34;
    localparam logic [7:0] PB_ALT_ADDR = 8'h38;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL1_HOST_RESET_BIT = 0;
    localparam int CTRL1_CFG_VALID_BIT = 1;
    localparam int CTRL1_CFG_LOCK_BIT = 2;
    localparam int CTRL1_SMI_TO_IRQ_BIT = 3;
    localparam int CTRL3_RESET_ON_ACCESS_BIT = 0;
    localparam int CTRL3_ALARM_REQ_BIT = 5;
    localparam int IEN2_ALARM_BIT = 5;
    localparam int PB_GATE_BIT = 5;
    localparam int CFG_LOW_MSB = 7;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int EVT_W = 8;
    localparam int STATE_W = 5;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] PB_DOUT_RESET = 8'h20;
    localparam logic [7:0] PB_ALT_MASK = 8'hdf;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ------------------------------------------------------------
    // apb answer phase
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WER_IDLE = 2'b01,
        WER_ANSWER = 2'b10
    } wer_apb_e;

endpackage

// ==== wer_top.sv ====
`timescale 1ns/100ps

// Behaviour
// R1: rtc alarm sets core alarm request bit
// R2: alarm request interrupts core only when enabled
// R3: firmware clears request before rtc alarm flag
// R4: four outputs: irq, power-up, smi, core wake
// R5: host outputs from host status, core from core
// R6: three host enables: power-up, smi, irq
// R7: host outputs hold until status or enable clears
// R8: smi is or of pm channels and events
// R9: power-up combines events and device irq wake
// R10: smi on own pin, optionally onto irq
// R11: core enable gates separate core status bits
// R12: core wake level high, or of three sources
// R13: firmware order: clear valid, low, high, lock
// R14: config base held in two byte registers
// R15: config base reset only by power-up reset
// R16: valid flag gates host configuration requests
// R17: lock blocks writes to config base bytes
// R18: keyboard fast reset output active low
// R19: software bit drives and releases fast reset
// R20: power-up reset plus access asserts host reset
// R21: gate pin from data-out bit, alt reads zero
// R22: gate pin drives high from reset
// R23: status clears on write one, not zero
// R24: output asserts for status and enable, any order
// R25: outputs registered, glitch free
module wer_top
    import wer_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic por_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [EVT_W-1:0] event_detect,
    input wire logic rtc_alarm_set,
    input wire logic [STATE_W-1:0] state_change_req,
    input wire logic [1:0] pm_smi_req,
    input wire logic ldev_wake_req,
    input wire logic lpc_frame_start,
    output logic power_up_request_out_n,
    output logic smi_out_n,
    output logic host_irq_out,
    output logic core_wake_interrupt,
    output logic kbd_fast_reset_out_n,
    output logic cfg_req_enable,
    output logic port_b_pin_five
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [EVT_W-1:0] host_event_status_reg;
    logic [EVT_W-1:0] host_powerup_route_enable_reg;
    logic [EVT_W-1:0] host_smi_route_enable_reg;
    logic [EVT_W-1:0] host_irq_route_enable_reg;
    logic [EVT_W-1:0] core_event_status_reg;
    logic [EVT_W-1:0] core_event_route_enable_reg;
    logic [STATE_W-1:0] ctrl2_status_reg;
    logic [7:0] ien2_reg;
    logic host_reset_sw_control_reg;
    logic config_base_valid_reg;
    logic config_base_lock_reg;
    logic smi_to_irq_reg;
    logic alarm_req_reg;
    logic reset_on_access_enable_reg;
    logic hw_host_reset_reg;
    logic [7:0] config_base_low_reg;
    logic [7:0] config_base_high_reg;
    logic [7:0] port_b_data_out_reg;
    logic [7:0] port_b_alt_func_reg;
    logic lpc_sync1_reg;
    logic lpc_sync2_reg;
    wer_apb_e apb_state_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    wire setup_cyc = psel && !penable && (apb_state_reg == WER_IDLE);
    wire wr_en = psel && penable && pwrite && (apb_state_reg == WER_ANSWER) && !pslverr_reg;
    wire [7:0] wb = pwdata[7:0];
    wire wr_hsts = wr_en && hit(paddr, HOST_STS_ADDR);
    wire wr_hpu = wr_en && hit(paddr, HOST_PU_EN_ADDR);
    wire wr_hsmi = wr_en && hit(paddr, HOST_SMI_EN_ADDR);
    wire wr_hirq = wr_en && hit(paddr, HOST_IRQ_EN_ADDR);
    wire wr_csts = wr_en && hit(paddr, CORE_STS_ADDR);
    wire wr_cen = wr_en && hit(paddr, CORE_EN_ADDR);
    wire wr_ctl1 = wr_en && hit(paddr, CTRL1_ADDR);
    wire wr_ctl2 = wr_en && hit(paddr, CTRL2_ADDR);
    wire wr_ctl3 = wr_en && hit(paddr, CTRL3_ADDR);
    wire wr_ien2 = wr_en && hit(paddr, IEN2_ADDR);
    wire wr_cfg_lo = wr_en && hit(paddr, CFG_LOW_ADDR);
    wire wr_cfg_hi = wr_en && hit(paddr, CFG_HIGH_ADDR);
    wire wr_pbd = wr_en && hit(paddr, PB_DOUT_ADDR);
    wire wr_pba = wr_en && hit(paddr, PB_ALT_ADDR);
    wire mapped = hit(paddr, HOST_STS_ADDR) || hit(paddr, HOST_PU_EN_ADDR)
        || hit(paddr, HOST_SMI_EN_ADDR) || hit(paddr, HOST_IRQ_EN_ADDR)
        || hit(paddr, SIG_VALUE_ADDR) || hit(paddr, CORE_STS_ADDR)
        || hit(paddr, CORE_EN_ADDR) || hit(paddr, CTRL1_ADDR)
        || hit(paddr, CTRL2_ADDR) || hit(paddr, CTRL3_ADDR)
        || hit(paddr, IEN2_ADDR) || hit(paddr, CFG_LOW_ADDR)
        || hit(paddr, CFG_HIGH_ADDR) || hit(paddr, PB_DOUT_ADDR)
        || hit(paddr, PB_ALT_ADDR);

    // ------------------------------------------------------------
    // event routing
    // ------------------------------------------------------------
    // R5 host from host status
    // R24 status and enable, any order
    wire pu_evt = |(host_event_status_reg & host_powerup_route_enable_reg);
    wire smi_evt = |(host_event_status_reg & host_smi_route_enable_reg);
    wire irq_evt = |(host_event_status_reg & host_irq_route_enable_reg);
    // R9 merge device irq wake
    wire pu_next = pu_evt || ldev_wake_req;
    // R8 merge pm channel smi
    wire smi_next = smi_evt || pm_smi_req[0] || pm_smi_req[1];
    // R10 smi redirected to irq
    wire irq_next = irq_evt || (smi_next && smi_to_irq_reg);
    // R11 core status gated separately
    // R12 or of three core sources
    // R2 alarm masked by its enable
    wire core_next = |(core_event_status_reg & core_event_route_enable_reg)
        || |(ctrl2_status_reg & ien2_reg[STATE_W-1:0])
        || (alarm_req_reg && ien2_reg[IEN2_ALARM_BIT]);
    // R18 active low, sw or hw source
    wire kbd_next_n = !(host_reset_sw_control_reg || hw_host_reset_reg);

    wire [7:0] ctl1_rd = {4'h0, smi_to_irq_reg, config_base_lock_reg,
        config_base_valid_reg, host_reset_sw_control_reg};
    wire [7:0] ctl3_rd = {2'h0, alarm_req_reg, 4'h0, reset_on_access_enable_reg};
    wire [7:0] sig_rd = {3'h0, !kbd_fast_reset_out_n, core_wake_interrupt,
        host_irq_out, !smi_out_n, !power_up_request_out_n};
    // R21 alt bit always reads zero
    wire [7:0] pba_rd = port_b_alt_func_reg & PB_ALT_MASK;

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = ZERO_BYTE;
        unique case (1'b1)
            hit(paddr, HOST_STS_ADDR): rd_byte = host_event_status_reg;
            hit(paddr, HOST_PU_EN_ADDR): rd_byte = host_powerup_route_enable_reg;
            hit(paddr, HOST_SMI_EN_ADDR): rd_byte = host_smi_route_enable_reg;
            hit(paddr, HOST_IRQ_EN_ADDR): rd_byte = host_irq_route_enable_reg;
            hit(paddr, SIG_VALUE_ADDR): rd_byte = sig_rd;
            hit(paddr, CORE_STS_ADDR): rd_byte = core_event_status_reg;
            hit(paddr, CORE_EN_ADDR): rd_byte = core_event_route_enable_reg;
            hit(paddr, CTRL1_ADDR): rd_byte = ctl1_rd;
            hit(paddr, CTRL2_ADDR): rd_byte = {3'h0, ctrl2_status_reg};
            hit(paddr, CTRL3_ADDR): rd_byte = ctl3_rd;
            hit(paddr, IEN2_ADDR): rd_byte = ien2_reg;
            hit(paddr, CFG_LOW_ADDR): rd_byte = config_base_low_reg;
            hit(paddr, CFG_HIGH_ADDR): rd_byte = config_base_high_reg;
            hit(paddr, PB_DOUT_ADDR): rd_byte = port_b_data_out_reg;
            hit(paddr, PB_ALT_ADDR): rd_byte = pba_rd;
            default: rd_byte = ZERO_BYTE;
        endcase
    end

    // ------------------------------------------------------------
    // apb slave: one wait-free access phase, data captured at setup
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || por_rst) begin
            apb_state_reg <= WER_IDLE;
            prdata_reg <= ZERO_WORD;
            pslverr_reg <= 1'b0;
        end else if (setup_cyc) begin
            apb_state_reg <= WER_ANSWER;
            prdata_reg <= {24'h000000, rd_byte};
            pslverr_reg <= !mapped;
        end else begin
            apb_state_reg <= WER_IDLE;
            pslverr_reg <= 1'b0;
        end
    end
    assign pready = (apb_state_reg == WER_ANSWER);
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // ------------------------------------------------------------
    // status registers: the set wins over a clear in the same cycle
    // ------------------------------------------------------------
    wire [EVT_W-1:0] hsts_clr = wr_hsts ? wb : ZERO_BYTE;
    wire [EVT_W-1:0] csts_clr = wr_csts ? wb : ZERO_BYTE;
    wire [STATE_W-1:0] cs2_clr = wr_ctl2 ? wb[STATE_W-1:0] : STATE_W'(0);
    always_ff @(posedge clk) begin
        if (rst || por_rst) begin
            host_event_status_reg <= ZERO_BYTE;
            core_event_status_reg <= ZERO_BYTE;
            ctrl2_status_reg <= STATE_W'(0);
            alarm_req_reg <= 1'b0;
        end else begin
            // R23 write one clears
            host_event_status_reg <= (host_event_status_reg & ~hsts_clr) | event_detect;
            core_event_status_reg <= (core_event_status_reg & ~csts_clr) | event_detect;
            ctrl2_status_reg <= (ctrl2_status_reg & ~cs2_clr) | state_change_req;
            // R1 alarm sets core request
            // R3 set wins so no alarm lost
            alarm_req_reg <= rtc_alarm_set
                || (alarm_req_reg && !(wr_ctl3 && wb[CTRL3_ALARM_REQ_BIT]));
        end
    end

    // ------------------------------------------------------------
    // enables and control bits
    // ------------------------------------------------------------
    // R6 three host routing enables
    always_ff @(posedge clk) begin
        if (rst || por_rst) begin
            host_powerup_route_enable_reg <= ZERO_BYTE;
            host_smi_route_enable_reg <= ZERO_BYTE;
            host_irq_route_enable_reg <= ZERO_BYTE;
            core_event_route_enable_reg <= ZERO_BYTE;
            ien2_reg <= ZERO_BYTE;
        end else begin
            if (wr_hpu) host_powerup_route_enable_reg <= wb;
            if (wr_hsmi) host_smi_route_enable_reg <= wb;
            if (wr_hirq) host_irq_route_enable_reg <= wb;
            if (wr_cen) core_event_route_enable_reg <= wb;
            if (wr_ien2) ien2_reg <= wb;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || por_rst) begin
            host_reset_sw_control_reg <= 1'b0;
            smi_to_irq_reg <= 1'b0;
            config_base_lock_reg <= 1'b0;
        end else if (wr_ctl1) begin
            // R19 write one drives, zero releases
            host_reset_sw_control_reg <= wb[CTRL1_HOST_RESET_BIT];
            smi_to_irq_reg <= wb[CTRL1_SMI_TO_IRQ_BIT];
            config_base_lock_reg <= wb[CTRL1_CFG_LOCK_BIT];
        end
    end

    // the enable must survive the power-up reset it acts during
    always_ff @(posedge clk) begin
        if (rst) begin
            reset_on_access_enable_reg <= 1'b0;
        end else if (wr_ctl3) begin
            reset_on_access_enable_reg <= wb[CTRL3_RESET_ON_ACCESS_BIT];
        end
    end

    // ------------------------------------------------------------
    // configuration base address
    // ------------------------------------------------------------
    // R13 firmware sequence: valid set once high byte lands
    // R17 lock blocks base writes
    wire cfg_lo_we = wr_cfg_lo && !config_base_lock_reg;
    wire cfg_hi_we = wr_cfg_hi && !config_base_lock_reg;
    // R15 only the power-up reset clears the base
    always_ff @(posedge clk) begin
        if (por_rst) begin
            config_base_low_reg <= ZERO_BYTE;
            config_base_high_reg <= ZERO_BYTE;
            config_base_valid_reg <= 1'b0;
        end else begin
            // R14 two byte registers
            if (cfg_lo_we) config_base_low_reg <= wb;
            if (cfg_hi_we) config_base_high_reg <= wb;
            // R16 valid while a base is held, write one clears
            if (cfg_hi_we) begin
                config_base_valid_reg <= 1'b1;
            end else if (wr_ctl1 && wb[CTRL1_CFG_VALID_BIT]) begin
                config_base_valid_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // lpc access during power-up reset
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            lpc_sync1_reg <= 1'b0;
            lpc_sync2_reg <= 1'b0;
            hw_host_reset_reg <= 1'b0;
        end else begin
            lpc_sync1_reg <= lpc_frame_start;
            lpc_sync2_reg <= lpc_sync1_reg;
            // R20 access seen during power-up reset
            if (!por_rst) begin
                hw_host_reset_reg <= 1'b0;
            end else if (reset_on_access_enable_reg && lpc_sync2_reg) begin
                hw_host_reset_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // gpio port b gate pin
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || por_rst) begin
            // R22 gate pin high from reset
            port_b_data_out_reg <= PB_DOUT_RESET;
            port_b_alt_func_reg <= ZERO_BYTE;
        end else begin
            if (wr_pbd) port_b_data_out_reg <= wb;
            // R21 alt bit ignores writes
            if (wr_pba) port_b_alt_func_reg <= wb & PB_ALT_MASK;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // R25 outputs from flops only
    // R4 four output kinds
    // R7 level held while status and enable stand
    always_ff @(posedge clk) begin
        if (rst || por_rst) begin
            power_up_request_out_n <= 1'b1;
            smi_out_n <= 1'b1;
            host_irq_out <= 1'b0;
            core_wake_interrupt <= 1'b0;
            cfg_req_enable <= 1'b0;
            port_b_pin_five <= 1'b1;
        end else begin
            power_up_request_out_n <= !pu_next;
            smi_out_n <= !smi_next;
            host_irq_out <= irq_next;
            core_wake_interrupt <= core_next;
            cfg_req_enable <= config_base_valid_reg;
            port_b_pin_five <= port_b_data_out_reg[PB_GATE_BIT];
        end
    end

    // fast reset is kept out of the power-up reset so it can act during it
    always_ff @(posedge clk) begin
        if (rst) begin
            kbd_fast_reset_out_n <= 1'b1;
        end else begin
            kbd_fast_reset_out_n <= kbd_next_n;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // R1 alarm to request
    alarm_sets_req_a: assert property (@(posedge clk) disable iff (rst || por_rst) // R1
        rtc_alarm_set |=> alarm_req_reg) else $error("alarm did not set request");

    // R2 enabled alarm gives core wake
    alarm_mask_a: assert property (@(posedge clk) disable iff (rst || por_rst) // R2
        (alarm_req_reg && ien2_reg[IEN2_ALARM_BIT]) |=> core_wake_interrupt)
        else $error("enabled alarm did not wake core");

    // R24 status and enable drive power-up request
    pu_route_a: assert property (@(posedge clk) disable iff (rst || por_rst) // R24
        (|(host_event_status_reg & host_powerup_route_enable_reg))
        |=> !power_up_request_out_n) else $error("power-up request missing");

    // R8 pm channel smi
    smi_merge_a: assert property (@(posedge clk) disable iff (rst || por_rst) // R8
        (|pm_smi_req) |=> !smi_out_n) else $error("pm smi not forwarded");

    // R7 output stays while cause stands
    irq_hold_a: assert property (@(posedge clk) disable iff (rst || por_rst) // R7
        (host_irq_out && $stable(host_event_status_reg) && $stable(host_irq_route_enable_reg)
        && !smi_to_irq_reg) |=> host_irq_out) else $error("irq dropped early");

    // R23 write zero keeps status
    w1c_zero_a: assert property (@(posedge clk) disable iff (rst || por_rst) // R23
        (wr_hsts && wb == ZERO_BYTE) |=> (host_event_status_reg
        == ($past(host_event_status_reg) | $past(event_detect))))
        else $error("zero write changed status");

    // R17 locked base unchanged
    cfg_lock_a: assert property (@(posedge clk) disable iff (por_rst) // R17
        (config_base_lock_reg && (wr_cfg_lo || wr_cfg_hi)) |=> $stable(config_base_low_reg)
        && $stable(config_base_high_reg)) else $error("locked base changed");

    // R19 software reset reaches pin in two edges
    sw_reset_a: assert property (@(posedge clk) disable iff (rst || por_rst) // R19
        (wr_ctl1 && wb[CTRL1_HOST_RESET_BIT]) |=> ##1 !kbd_fast_reset_out_n)
        else $error("fast reset not asserted");

    // R21 alt bit stays zero
    alt_zero_a: assert property (@(posedge clk) disable iff (rst || por_rst) // R21
        wr_pba |=> !port_b_alt_func_reg[PB_GATE_BIT]) else $error("alt bit set");

endmodule

// ==== wer_host_model.sv ====
`timescale 1ns/100ps
module wer_host_model (
    input wire logic clk,
    input wire logic access_req,
    input wire logic kbd_fast_reset_out_n,
    output logic lpc_frame_start,
    output logic host_in_reset
);
    // frame start comes from a register updated on the rising edge, so the sampling edge sees its previous value
    always_ff @(posedge clk) begin
        lpc_frame_start <= access_req;
    end
    assign host_in_reset = ~kbd_fast_reset_out_n;
endmodule

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench
    import wer_pkg::*;
;
    logic clk, rst, por_rst, psel, penable, pwrite, rtc_alarm_set, ldev_wake_req, access_req;
    logic [7:0] paddr, event_detect;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, pu_n, smi_n, irq, cwake, kbd_n, cfg_en, gate, lpc, host_rst;
    logic [STATE_W-1:0] state_change_req;
    logic [1:0] pm_smi_req;
    int n_errors, n_compared, cycles;
    wire [6:0] outs = {pu_n, smi_n, irq, cwake, kbd_n, cfg_en, gate};

    wer_top i_wer_top (.clk(clk), .rst(rst), .por_rst(por_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_detect(event_detect), .rtc_alarm_set(rtc_alarm_set),
        .state_change_req(state_change_req), .pm_smi_req(pm_smi_req),
        .ldev_wake_req(ldev_wake_req), .lpc_frame_start(lpc), .power_up_request_out_n(pu_n),
        .smi_out_n(smi_n), .host_irq_out(irq), .core_wake_interrupt(cwake),
        .kbd_fast_reset_out_n(kbd_n), .cfg_req_enable(cfg_en), .port_b_pin_five(gate));
    wer_host_model i_wer_host_model (.clk(clk), .access_req(access_req),
        .kbd_fast_reset_out_n(kbd_n), .lpc_frame_start(lpc), .host_in_reset(host_rst));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // holds the request until pready is seen at an edge; no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask
    task automatic pulse(input logic [7:0] ev, input logic al, input logic [4:0] st);
        event_detect <= ev;
        rtc_alarm_set <= al;
        state_change_req <= st;
        @(posedge clk);
        event_detect <= 8'h00;
        rtc_alarm_set <= 1'b0;
        state_change_req <= 5'h00;
        tick(2);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_gate();
        chk(outs, 7'h65);
        rd(PB_DOUT_ADDR, 32'h20);
        wr(PB_ALT_ADDR, 32'hff);
        rd(PB_ALT_ADDR, 32'hdf);
        wr(PB_DOUT_ADDR, 32'h00);
        tick(2);
        chk(gate, 1'b0);
        wr(PB_DOUT_ADDR, 32'h20);
    endtask
    task automatic t_host_route();
        pulse(8'h08, 1'b0, 5'h00);
        chk(outs, 7'h65);
        rd(HOST_STS_ADDR, 32'h08);
        wr(HOST_PU_EN_ADDR, 32'h08);
        tick(2);
        chk(outs, 7'h25);
        wr(HOST_SMI_EN_ADDR, 32'h08);
        wr(HOST_IRQ_EN_ADDR, 32'h08);
        wr(HOST_STS_ADDR, 32'h00);
        tick(2);
        chk(outs, 7'h15);
        wr(HOST_SMI_EN_ADDR, 32'h00);
        tick(2);
        chk(outs, 7'h35);
        rd(HOST_STS_ADDR, 32'h08);
        wr(HOST_STS_ADDR, 32'h08);
        tick(2);
        chk(outs, 7'h65);
        wr(HOST_PU_EN_ADDR, 32'h02);
        pulse(8'h02, 1'b0, 5'h00);
        tick(2);
        chk(outs, 7'h25);
        wr(HOST_STS_ADDR, 32'h02);
        wr(HOST_PU_EN_ADDR, 32'h00);
        wr(HOST_IRQ_EN_ADDR, 32'h00);
    endtask
    task automatic t_core_route();
        rd(CORE_STS_ADDR, 32'h0a);
        wr(CORE_EN_ADDR, 32'h08);
        tick(2);
        chk(outs, 7'h6d);
        rd(SIG_VALUE_ADDR, 32'h08);
        wr(CORE_STS_ADDR, 32'h0a);
        wr(CORE_EN_ADDR, 32'h00);
        pulse(8'h00, 1'b1, 5'h01);
        rd(CTRL3_ADDR, 32'h20);
        chk(cwake, 1'b0);
        wr(IEN2_ADDR, 32'h20);
        tick(2);
        chk(cwake, 1'b1);
        // alarm request cleared first, before any clock-side flag
        wr(CTRL3_ADDR, 32'h20);
        tick(2);
        chk(cwake, 1'b0);
        wr(IEN2_ADDR, 32'h01);
        tick(2);
        chk(cwake, 1'b1);
        wr(CTRL2_ADDR, 32'h01);
        wr(IEN2_ADDR, 32'h00);
    endtask
    task automatic t_merge();
        pm_smi_req <= 2'b10;
        tick(3);
        chk(smi_n, 1'b0);
        pm_smi_req <= 2'b00;
        ldev_wake_req <= 1'b1;
        tick(3);
        chk({pu_n, smi_n}, 2'b01);
        ldev_wake_req <= 1'b0;
        wr(CTRL1_ADDR, 32'h08);
        pm_smi_req <= 2'b01;
        tick(3);
        chk({smi_n, irq}, 2'b01);
        pm_smi_req <= 2'b00;
        wr(CTRL1_ADDR, 32'h00);
        tick(3);
        chk(outs, 7'h65);
    endtask
    task automatic t_cfg_kbd();
        logic [31:0] q;
        logic e;
        wr(CTRL1_ADDR, 32'h02);
        wr(CFG_LOW_ADDR, 32'h2e);
        wr(CFG_HIGH_ADDR, 32'h4e);
        wr(CTRL1_ADDR, 32'h04);
        tick(2);
        chk(cfg_en, 1'b1);
        rd(CTRL1_ADDR, 32'h06);
        wr(CFG_LOW_ADDR, 32'h11);
        rd(CFG_LOW_ADDR, 32'h2e);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        @(posedge clk);
        rd(CFG_LOW_ADDR, 32'h2e);
        rd(CFG_HIGH_ADDR, 32'h4e);
        wr(CTRL1_ADDR, 32'h02);
        tick(2);
        chk(cfg_en, 1'b0);
        wr(CTRL1_ADDR, 32'h01);
        tick(2);
        chk({kbd_n, host_rst}, 2'b01);
        wr(CTRL1_ADDR, 32'h00);
        tick(2);
        chk({kbd_n, host_rst}, 2'b10);
        wr(8'h3c, 32'hff);
        apb(1'b0, 8'h3c, 32'h0, q, e);
        chk(q, 32'h0);
        chk(e, 1'b1);
    endtask
    task automatic t_power_up();
        int n;
        wr(CTRL3_ADDR, 32'h01);
        por_rst <= 1'b1;
        tick(3);
        chk(kbd_n, 1'b1);
        access_req <= 1'b1;
        n = 0;
        while (kbd_n !== 1'b0 && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk(kbd_n, 1'b0);
        access_req <= 1'b0;
        por_rst <= 1'b0;
        tick(3);
        chk(outs, 7'h65);
        rd(CFG_LOW_ADDR, 32'h00);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        {rst, por_rst} = 2'b11;
        {psel, penable, pwrite, rtc_alarm_set, ldev_wake_req, access_req} = '0;
        {paddr, event_detect, pwdata, state_change_req, pm_smi_req} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        por_rst <= 1'b0;
        @(posedge clk);
        t_reset_gate();
        t_host_route();
        t_core_route();
        t_merge();
        t_cfg_kbd();
        t_power_up();
        stop_test();
    end
endmodule
